// [admin_queue_doorbell_regs.sv]
// admin queue attribute/base registers and submission tail doorbells
`timescale 1ns/1ns
module admin_queue_doorbell_regs (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // memory-mapped register access
    input wire aq_regs_pkg::reg_req_type reg_req_i,
    output aq_regs_pkg::reg_rsp_type reg_rsp_o,
    // controller configuration seen by this block
    input wire logic [aq_regs_pkg::STRIDE_W-1:0] doorbell_stride_i,
    input wire logic [aq_regs_pkg::MPS_W-1:0] memory_page_size_i,
    input wire logic [aq_regs_pkg::NUM_SQ-1:0] sq_alloc_i,
    input wire logic [aq_regs_pkg::NUM_SQ-1:0][aq_regs_pkg::SIZE_W-1:0]
        io_sq_size_m1_i,
    input wire logic [aq_regs_pkg::NUM_SQ-1:0] sq_head_adv_i,
    // completion routing request from the command engine
    input wire logic cpl_req_i,
    input wire logic [aq_regs_pkg::QID_W-1:0] cpl_sq_id_i,
    input wire logic [15:0] cpl_io_cq_id_i,
    input wire logic [aq_regs_pkg::VEC_W-1:0] cpl_io_vector_i,
    // admin queue setup
    output logic [63:0] admin_sq_base_o,
    output logic [63:0] admin_cq_base_o,
    output logic [aq_regs_pkg::SIZE_W-1:0] admin_sq_size_o,
    output logic [aq_regs_pkg::SIZE_W-1:0] admin_cq_size_o,
    output logic admin_size_ok_o,
    output logic admin_base_aligned_o,
    output logic [15:0] admin_qid_o,
    output logic [aq_regs_pkg::VEC_W-1:0] admin_cq_vector_o,
    output logic [aq_regs_pkg::NUM_SQ-1:0] sq_is_admin_o,
    // per queue doorbell state
    output logic [aq_regs_pkg::NUM_SQ-1:0] sq_notify_o,
    output logic [aq_regs_pkg::NUM_SQ-1:0][aq_regs_pkg::CNT_W-1:0]
        sq_added_o,
    output logic [aq_regs_pkg::NUM_SQ-1:0][aq_regs_pkg::CNT_W-1:0]
        sq_pending_o,
    output logic [aq_regs_pkg::NUM_SQ-1:0][aq_regs_pkg::SIZE_W-1:0]
        sq_head_o,
    // completion routing answer
    output logic cpl_valid_o,
    output logic [15:0] cpl_cq_id_o,
    output logic [aq_regs_pkg::VEC_W-1:0] cpl_vector_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [aq_regs_pkg::DATA_W-1:0] aqa_q; // both size fields
    logic [aq_regs_pkg::BASE_W-1:0] asq_base_q; // submission base 63:12
    logic [aq_regs_pkg::BASE_W-1:0] acq_base_q; // completion base 63:12
    logic wr; // write accepted this cycle
    logic db_hit; // address falls on a doorbell
    logic db_sq; // tail doorbell rather than head doorbell
    logic [aq_regs_pkg::QID_W-1:0] db_qid; // queue addressed
    logic [aq_regs_pkg::NUM_SQ-1:0] db_wr; // per queue tail write
    logic [aq_regs_pkg::NUM_SQ-1:0] alloc; // queues that exist
    logic [aq_regs_pkg::NUM_SQ-1:0][aq_regs_pkg::TAIL_W-1:0] tail;
    logic [aq_regs_pkg::NUM_SQ-1:0][aq_regs_pkg::SIZE_W-1:0] slot_size;
    logic [aq_regs_pkg::DATA_W-1:0] rdata_d; // read mux
    logic [aq_regs_pkg::BASE_W-1:0] page_mask; // bits a page must clear
    aq_regs_pkg::reg_rsp_type rsp_q; // registered answer
    logic size_ok_q;
    logic aligned_q;
    logic cpl_valid_q;
    logic [15:0] cpl_cq_id_q;
    logic [aq_regs_pkg::VEC_W-1:0] cpl_vector_q;
    logic [15:0] qid_q;
    logic [aq_regs_pkg::VEC_W-1:0] vector_q;
    logic [aq_regs_pkg::NUM_SQ-1:0] is_admin_q;

    // no wait states
    assign wr = reg_req_i.valid && reg_req_i.write;

    ////////////////////////////////////////////////////////////////////////
    // doorbell decode
    // combinational
    db_decode u_db_decode (
        .addr_i(reg_req_i.addr),
        .stride_i(doorbell_stride_i),
        .hit_o(db_hit),
        .sq_o(db_sq),
        .qid_o(db_qid)
    );

    // alloc gates writes
    // the admin queue always exists; others only once created
    always_comb begin
        alloc = sq_alloc_i;
        alloc[0] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // per queue tail slots; queue 0 takes the admin size
    for (genvar i = 0; i < aq_regs_pkg::NUM_SQ; i++) begin : g_slot
        // writes to absent queues are dropped, not stored
        assign db_wr[i] = wr && db_hit && db_sq
                       && (db_qid == aq_regs_pkg::QID_W'(i)) && alloc[i];
        // admin size
        if (i == 0) begin : g_admin
            assign slot_size[i] =
                aqa_q[aq_regs_pkg::ADMIN_SQ_SIZE_MSB:aq_regs_pkg::ADMIN_SQ_SIZE_LSB];
        end else begin : g_io
            assign slot_size[i] = io_sq_size_m1_i[i];
        end
        // one ring each
        sq_tail_slot u_slot (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .wr_i(db_wr[i]),
            .wdata_i(reg_req_i.wdata[aq_regs_pkg::TAIL_W-1:0]),
            .size_m1_i(slot_size[i]),
            .head_adv_i(sq_head_adv_i[i]),
            .tail_o(tail[i]),
            .head_o(sq_head_o[i]),
            .pending_o(sq_pending_o[i]),
            .added_o(sq_added_o[i]),
            .notify_o(sq_notify_o[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // queue attributes: only the two size fields hold bits
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // zero sizes
            aqa_q <= aq_regs_pkg::AQA_RESET;
        end else if (wr && (reg_req_i.addr == aq_regs_pkg::OFF_AQA)) begin
            // reserved 31:28 and 15:12 stay zero
            aqa_q <= reg_req_i.wdata & aq_regs_pkg::AQA_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // admin submission base, written as two dwords
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // base zero
            asq_base_q <= aq_regs_pkg::BASE_RESET;
        end else if (wr && (reg_req_i.addr == aq_regs_pkg::OFF_ASQ_LO)) begin
            // bits 11:0 of the write are discarded
            asq_base_q[19:0] <= reg_req_i.wdata[31:aq_regs_pkg::BASE_LSB];
        end else if (wr && (reg_req_i.addr == aq_regs_pkg::OFF_ASQ_HI)) begin
            // high dword
            asq_base_q[51:20] <= reg_req_i.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // admin completion base, written as two dwords
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // base zero
            acq_base_q <= aq_regs_pkg::BASE_RESET;
        end else if (wr && (reg_req_i.addr == aq_regs_pkg::OFF_ACQ_LO)) begin
            // drop 11:0
            acq_base_q[19:0] <= reg_req_i.wdata[31:aq_regs_pkg::BASE_LSB];
        end else if (wr && (reg_req_i.addr == aq_regs_pkg::OFF_ACQ_HI)) begin
            // high dword
            acq_base_q[51:20] <= reg_req_i.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = 32'h00000000;
        // exact match
        unique case (reg_req_i.addr)
            aq_regs_pkg::OFF_AQA: rdata_d = aqa_q;
            aq_regs_pkg::OFF_ASQ_LO: begin
                rdata_d = {asq_base_q[19:0], 12'h000};
            end
            aq_regs_pkg::OFF_ASQ_HI: rdata_d = asq_base_q[51:20];
            aq_regs_pkg::OFF_ACQ_LO: begin
                rdata_d = {acq_base_q[19:0], 12'h000};
            end
            aq_regs_pkg::OFF_ACQ_HI: rdata_d = acq_base_q[51:20];
            default: begin
                // tails read back for debug, upper half zero
                if (db_hit && db_sq) begin
                    rdata_d = {16'h0000, tail[db_qid]};
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // one-cycle answer to every access
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // no ack in reset
            rsp_q <= '0;
        end else begin
            // ack every access
            rsp_q.ack <= reg_req_i.valid;
            // writes answer zero so a stale read never leaks through
            rsp_q.rdata <= (reg_req_i.valid && !reg_req_i.write)
                         ? rdata_d : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // setup checks; misuse is flagged, never corrected
    always_comb begin
        // below the page
        page_mask = (52'h0000000000001 << memory_page_size_i)
                  - 52'h0000000000001;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // zero is aligned
            size_ok_q <= 1'b0;
            aligned_q <= 1'b1;
        end else begin
            // two entries at least; 4096 is the field's ceiling
            size_ok_q <= (aqa_q[aq_regs_pkg::ADMIN_SQ_SIZE_MSB:aq_regs_pkg::ADMIN_SQ_SIZE_LSB]
                          >= aq_regs_pkg::MIN_SIZE_M1)
                      && (aqa_q[aq_regs_pkg::ADMIN_CQ_SIZE_MSB:aq_regs_pkg::ADMIN_CQ_SIZE_LSB]
                          >= aq_regs_pkg::MIN_SIZE_M1);
            aligned_q <= ((asq_base_q & page_mask) == aq_regs_pkg::BASE_RESET)
                      && ((acq_base_q & page_mask)
                          == aq_regs_pkg::BASE_RESET);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fixed admin identity, vector and arbitration marking
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // fixed in reset
            qid_q <= aq_regs_pkg::ADMIN_QID;
            vector_q <= aq_regs_pkg::ADMIN_CQ_VECTOR;
            is_admin_q <= '0;
        end else begin
            qid_q <= aq_regs_pkg::ADMIN_QID;
            vector_q <= aq_regs_pkg::ADMIN_CQ_VECTOR;
            // arbiter applies its own scheme to the marked queue
            is_admin_q <= {{(aq_regs_pkg::NUM_SQ-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion routing: admin commands always land in queue 0
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // admin route
            cpl_valid_q <= 1'b0;
            cpl_cq_id_q <= aq_regs_pkg::ADMIN_QID;
            cpl_vector_q <= aq_regs_pkg::ADMIN_CQ_VECTOR;
        end else begin
            cpl_valid_q <= cpl_req_i;
            if (cpl_req_i) begin
                if (cpl_sq_id_i == '0) begin
                    cpl_cq_id_q <= aq_regs_pkg::ADMIN_QID;
                    cpl_vector_q <= aq_regs_pkg::ADMIN_CQ_VECTOR;
                end else begin
                    // io route
                    cpl_cq_id_q <= cpl_io_cq_id_i;
                    cpl_vector_q <= cpl_io_vector_i;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // all from flops
    assign reg_rsp_o = rsp_q;
    assign admin_sq_base_o = {asq_base_q, 12'h000};
    assign admin_cq_base_o = {acq_base_q, 12'h000};
    assign admin_sq_size_o =
        aqa_q[aq_regs_pkg::ADMIN_SQ_SIZE_MSB:aq_regs_pkg::ADMIN_SQ_SIZE_LSB];
    assign admin_cq_size_o =
        aqa_q[aq_regs_pkg::ADMIN_CQ_SIZE_MSB:aq_regs_pkg::ADMIN_CQ_SIZE_LSB];
    assign admin_size_ok_o = size_ok_q;
    assign admin_base_aligned_o = aligned_q;
    assign admin_qid_o = qid_q;
    assign admin_cq_vector_o = vector_q;
    assign sq_is_admin_o = is_admin_q;
    assign cpl_valid_o = cpl_valid_q;
    assign cpl_cq_id_o = cpl_cq_id_q;
    assign cpl_vector_o = cpl_vector_q;

endmodule : admin_queue_doorbell_regs

// [aq_regs_pkg.sv]
// shared constants and carrier types for the admin queue and doorbell regs
package aq_regs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int unsigned NUM_SQ = 4; // submission queues with a doorbell
    localparam int unsigned QID_W = 2; // bits to pick one of NUM_SQ
    localparam int unsigned ADDR_W = 16; // register byte address width
    localparam int unsigned DATA_W = 32; // register data width
    localparam int unsigned SIZE_W = 12; // 0's based queue size field
    localparam int unsigned TAIL_W = 16; // tail pointer field
    localparam int unsigned CNT_W = 13; // entry counts up to 4096
    localparam int unsigned BASE_W = 52; // base address bits 63:12
    localparam int unsigned STRIDE_W = 4; // doorbell stride input
    localparam int unsigned MPS_W = 4; // memory page size input
    localparam int unsigned VEC_W = 11; // interrupt vector number

    ////////////////////////////////////////////////////////////////////////
    // byte offsets
    localparam logic [ADDR_W-1:0] OFF_AQA = 16'h0024;
    localparam logic [ADDR_W-1:0] OFF_ASQ_LO = 16'h0028;
    localparam logic [ADDR_W-1:0] OFF_ASQ_HI = 16'h002c;
    localparam logic [ADDR_W-1:0] OFF_ACQ_LO = 16'h0030;
    localparam logic [ADDR_W-1:0] OFF_ACQ_HI = 16'h0034;
    localparam logic [ADDR_W-1:0] OFF_DB_BASE = 16'h1000;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned ADMIN_CQ_SIZE_LSB = 16;
    localparam int unsigned ADMIN_CQ_SIZE_MSB = 27;
    localparam int unsigned ADMIN_SQ_SIZE_LSB = 0;
    localparam int unsigned ADMIN_SQ_SIZE_MSB = 11;
    localparam int unsigned BASE_LSB = 12; // low twelve bits read zero
    localparam int unsigned DB_UNIT_SHIFT = 2; // one doorbell is 4 << stride
    localparam logic [DATA_W-1:0] AQA_WMASK = 32'h0fff0fff;

    ////////////////////////////////////////////////////////////////////////
    // reset values and fixed identities
    localparam logic [DATA_W-1:0] AQA_RESET = 32'h00000000;
    localparam logic [BASE_W-1:0] BASE_RESET = 52'h0000000000000;
    localparam logic [TAIL_W-1:0] TAIL_RESET = 16'h0000;
    localparam logic [SIZE_W-1:0] HEAD_RESET = 12'h000;
    localparam logic [CNT_W-1:0] CNT_RESET = 13'h0000;
    localparam logic [SIZE_W-1:0] MIN_SIZE_M1 = 12'h001; // two entries
    localparam logic [15:0] ADMIN_QID = 16'h0000;
    localparam logic [VEC_W-1:0] ADMIN_CQ_VECTOR = 11'h000;

    ////////////////////////////////////////////////////////////////////////
    // register access carriers
    typedef struct packed {
        logic valid; // access in this cycle
        logic write; // 1 write, 0 read
        logic [ADDR_W-1:0] addr; // byte address, dword aligned
        logic [DATA_W-1:0] wdata; // write data
    } reg_req_type;

    typedef struct packed {
        logic ack; // one cycle after the access
        logic [DATA_W-1:0] rdata; // read data, zero for writes
    } reg_rsp_type;

endpackage : aq_regs_pkg

// [db_decode.sv]
// doorbell address decoder: byte address and stride to queue and kind
`timescale 1ns/1ns
module db_decode (
    input wire logic [aq_regs_pkg::ADDR_W-1:0] addr_i,
    input wire logic [aq_regs_pkg::STRIDE_W-1:0] stride_i,
    output logic hit_o,
    output logic sq_o,
    output logic [aq_regs_pkg::QID_W-1:0] qid_o
);

    logic [aq_regs_pkg::ADDR_W-1:0] rel; // offset into the doorbell area
    logic [4:0] shift; // log2 of one doorbell's span
    logic [31:0] mask; // bits below one doorbell span
    logic [31:0] idx; // doorbell slot number, 2y or 2y+1

    ////////////////////////////////////////////////////////////////////////
    // slot = (addr - 1000h) / (4 << stride); even slots are tails
    always_comb begin
        rel = addr_i - aq_regs_pkg::OFF_DB_BASE;
        shift = 5'(aq_regs_pkg::DB_UNIT_SHIFT) + {1'b0, stride_i};
        mask = (32'h00000001 << shift) - 32'h00000001;
        idx = {16'h0000, rel} >> shift;
        sq_o = ~idx[0];
        qid_o = idx[aq_regs_pkg::QID_W:1]; // y = slot / 2
        // misaligned or past the last queue: not a doorbell
        hit_o = (addr_i >= aq_regs_pkg::OFF_DB_BASE)
              && (({16'h0000, rel} & mask) == 32'h00000000)
              && ((idx >> (aq_regs_pkg::QID_W + 1)) == 32'h00000000);
    end

endmodule : db_decode

// [sq_tail_slot.sv]
// one submission queue: tail doorbell, internal head, ring counts
`timescale 1ns/1ns
module sq_tail_slot (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [aq_regs_pkg::TAIL_W-1:0] wdata_i,
    input wire logic [aq_regs_pkg::SIZE_W-1:0] size_m1_i,
    input wire logic head_adv_i,
    output logic [aq_regs_pkg::TAIL_W-1:0] tail_o,
    output logic [aq_regs_pkg::SIZE_W-1:0] head_o,
    output logic [aq_regs_pkg::CNT_W-1:0] pending_o,
    output logic [aq_regs_pkg::CNT_W-1:0] added_o,
    output logic notify_o
);

    logic [aq_regs_pkg::TAIL_W-1:0] tail_q; // last written tail
    logic [aq_regs_pkg::TAIL_W-1:0] tail_d;
    logic [aq_regs_pkg::SIZE_W-1:0] head_q; // consumer position
    logic [aq_regs_pkg::SIZE_W-1:0] head_d;
    logic [aq_regs_pkg::CNT_W-1:0] pending_q; // entries still queued
    logic [aq_regs_pkg::CNT_W-1:0] added_q; // entries added by the write one cycle back, else zero
    logic notify_q; // one cycle after a doorbell write

    ////////////////////////////////////////////////////////////////////////
    // distance from one ring position to another, modulo size+1
    function automatic logic [aq_regs_pkg::CNT_W-1:0] ring_dist(
        input logic [aq_regs_pkg::SIZE_W-1:0] to_p,
        input logic [aq_regs_pkg::SIZE_W-1:0] from_p,
        input logic [aq_regs_pkg::SIZE_W-1:0] size_m1
    );
        logic [13:0] span;
        logic [13:0] raw;
        span = {2'b00, size_m1} + 14'h0001;
        if (to_p >= from_p) begin
            raw = {2'b00, to_p} - {2'b00, from_p};
        end else begin
            // pointer rolled over zero since from_p
            raw = {2'b00, to_p} + span - {2'b00, from_p};
        end
        ring_dist = raw[aq_regs_pkg::CNT_W-1:0];
    endfunction : ring_dist

    ////////////////////////////////////////////////////////////////////////
    // next tail and head
    always_comb begin
        tail_d = tail_q;
        if (wr_i) begin
            tail_d = wdata_i; // overwrite, no accumulation
        end
        head_d = head_q;
        // head only moves while something is queued
        if (head_adv_i && (pending_q != aq_regs_pkg::CNT_RESET)) begin
            if (head_q >= size_m1_i) begin
                head_d = aq_regs_pkg::HEAD_RESET; // roll to zero
            end else begin
                head_d = head_q + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tail and head registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tail_q <= aq_regs_pkg::TAIL_RESET;
            head_q <= aq_regs_pkg::HEAD_RESET;
        end else begin
            tail_q <= tail_d;
            head_q <= head_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pending count; equal pointers mean empty, giving zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pending_q <= aq_regs_pkg::CNT_RESET;
        end else begin
            pending_q <= ring_dist(tail_d[aq_regs_pkg::SIZE_W-1:0],
                                   head_d, size_m1_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // new-command notice and count of commands added
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            added_q <= aq_regs_pkg::CNT_RESET;
            notify_q <= 1'b0;
        end else begin
            notify_q <= wr_i; // new work waiting
            if (wr_i) begin
                // new tail minus old tail, wrap allowed
                added_q <= ring_dist(wdata_i[aq_regs_pkg::SIZE_W-1:0],
                                     tail_q[aq_regs_pkg::SIZE_W-1:0],
                                     size_m1_i);
            end else begin
                added_q <= aq_regs_pkg::CNT_RESET;
            end
        end
    end

    assign tail_o = tail_q;
    assign head_o = head_q;
    assign pending_o = pending_q;
    assign added_o = added_q;
    assign notify_o = notify_q;

endmodule : sq_tail_slot

// [aq_regs_checker_sva.sv]
// assertion checker for the admin queue and doorbell registers
`timescale 1ns/1ns
module aq_regs_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire aq_regs_pkg::reg_req_type reg_req_i,
    input wire aq_regs_pkg::reg_rsp_type reg_rsp_o,
    input wire logic [63:0] admin_sq_base_o,
    input wire logic [63:0] admin_cq_base_o,
    input wire logic [11:0] admin_sq_size_o,
    input wire logic [11:0] admin_cq_size_o,
    input wire logic [15:0] admin_qid_o,
    input wire logic [3:0] sq_notify_o,
    input wire logic cpl_req_i,
    input wire logic [1:0] cpl_sq_id_i,
    input wire logic cpl_valid_o,
    input wire logic [15:0] cpl_cq_id_o,
    input wire logic [10:0] cpl_vector_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // shared write decodes
    wire wr = reg_req_i.valid && reg_req_i.write;
    wire aqa_wr = wr && reg_req_i.addr == 16'h0024;
    ////////////////////////////////////////////////////////////////////////
    property p_ack; reg_req_i.valid |=> reg_rsp_o.ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_sqsz;
        aqa_wr |=> admin_sq_size_o == $past(reg_req_i.wdata[11:0]);
    endproperty
    a_sqsz: assert property (p_sqsz) else $error("sq size");
    property p_cqsz;
        aqa_wr |=> admin_cq_size_o == $past(reg_req_i.wdata[27:16]);
    endproperty
    a_cqsz: assert property (p_cqsz) else $error("cq size");
    property p_sqlo; wr && reg_req_i.addr == 16'h0028 |=>
        admin_sq_base_o[31:0] == {$past(reg_req_i.wdata[31:12]), 12'h0};
    endproperty
    a_sqlo: assert property (p_sqlo) else $error("sq base low");
    property p_cqlo; wr && reg_req_i.addr == 16'h0030 |=>
        admin_cq_base_o[31:0] == {$past(reg_req_i.wdata[31:12]), 12'h0};
    endproperty
    a_cqlo: assert property (p_cqlo) else $error("cq base low");
    property p_qid; admin_qid_o == 16'h0000; endproperty
    a_qid: assert property (p_qid) else $error("admin qid");
    // queue zero doorbell sits at the base for every stride
    property p_db; wr && reg_req_i.addr == 16'h1000 |=> sq_notify_o[0];
    endproperty
    a_db: assert property (p_db) else $error("no notify");
    property p_route; cpl_req_i && cpl_sq_id_i == 2'h0 |=> cpl_valid_o &&
        cpl_cq_id_o == 16'h0000 && cpl_vector_o == 11'h000;
    endproperty
    a_route: assert property (p_route) else $error("admin route");
    c_db: cover property (p_db);
    c_aqa: cover property (aqa_wr);
    c_cpl: cover property (cpl_valid_o);
endmodule : aq_regs_checker
bind admin_queue_doorbell_regs aq_regs_checker u_chk (.clk_i, .rst_n_i,
    .reg_req_i, .reg_rsp_o, .admin_sq_base_o, .admin_cq_base_o,
    .admin_sq_size_o, .admin_cq_size_o, .admin_qid_o, .sq_notify_o,
    .cpl_req_i, .cpl_sq_id_i, .cpl_valid_o, .cpl_cq_id_o, .cpl_vector_o);

// [admin_queue_doorbell_regs_test.sv]
// self-checking bench for the admin queue and doorbell registers
`timescale 1ns/1ns
module admin_queue_doorbell_regs_test;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    aq_regs_pkg::reg_req_type reg_req_i = '0;
    aq_regs_pkg::reg_rsp_type reg_rsp_o;
    logic [3:0] doorbell_stride_i = 4'h0, memory_page_size_i = 4'h0;
    logic [3:0] sq_alloc_i = 4'h3, sq_head_adv_i = 4'h0, sq_is_admin_o;
    logic [3:0][11:0] io_sq_size_m1_i = {4{12'h00f}};
    logic cpl_req_i = 1'b0, cpl_valid_o, admin_size_ok_o, admin_base_aligned_o;
    logic [1:0] cpl_sq_id_i = 2'h0;
    logic [15:0] cpl_io_cq_id_i = 16'h0005, admin_qid_o, cpl_cq_id_o;
    logic [10:0] cpl_io_vector_i = 11'h003, admin_cq_vector_o, cpl_vector_o;
    logic [63:0] admin_sq_base_o, admin_cq_base_o;
    logic [11:0] admin_sq_size_o, admin_cq_size_o;
    logic [3:0] sq_notify_o, nt; // nt: notify seen with the ack
    logic [3:0][12:0] sq_added_o, sq_pending_o, ad; // ad: added at ack
    logic [3:0][11:0] sq_head_o;
    logic [31:0] rdv; // read data of the last access
    logic [15:0] offs [7] = '{16'h0024, 16'h0028, 16'h002c, 16'h0030,
        16'h0034, 16'h1000, 16'h0040};
    int err_total = 0, comparisons = 0;
    admin_queue_doorbell_regs DUT (.clk_i, .rst_n_i, .reg_req_i, .reg_rsp_o,
        .doorbell_stride_i, .memory_page_size_i, .sq_alloc_i, .io_sq_size_m1_i,
        .sq_head_adv_i, .cpl_req_i, .cpl_sq_id_i, .cpl_io_cq_id_i,
        .cpl_io_vector_i, .admin_sq_base_o, .admin_cq_base_o, .admin_sq_size_o,
        .admin_cq_size_o, .admin_size_ok_o, .admin_base_aligned_o,
        .admin_qid_o, .admin_cq_vector_o, .sq_is_admin_o, .sq_notify_o,
        .sq_added_o, .sq_pending_o, .sq_head_o, .cpl_valid_o, .cpl_cq_id_o,
        .cpl_vector_o);
    always #5 clk_i = ~clk_i; // 100 MHz
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk
    // one access; answer taken a cycle later
    task automatic acc(input logic w, input logic [15:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        #1 reg_req_i = {1'b1, w, a, d};
        @(posedge clk_i);
        #1 reg_req_i.valid = 1'b0;
        chk(reg_rsp_o.ack, 1'b1);
        rdv = reg_rsp_o.rdata;
        nt = sq_notify_o;
        ad = sq_added_o;
    endtask : acc
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        // reset values, unmapped place last
        foreach (offs[i]) begin
            acc(1'b0, offs[i], 32'h0);
            chk(rdv, 64'h0);
        end
        chk(admin_qid_o, 16'h0);
        chk(sq_is_admin_o, 4'h1);
        chk(admin_cq_vector_o, 11'h0);
        acc(1'b1, 16'h0024, 32'hffffffff);
        acc(1'b0, 16'h0024, 32'h0);
        chk(rdv, 32'h0fff0fff);
        chk(admin_sq_size_o, 12'hfff);
        chk(admin_cq_size_o, 12'hfff);
        acc(1'b1, 16'h0024, 32'h00000007);
        acc(1'b0, 16'h0024, 32'h0);
        chk(admin_size_ok_o, 1'b0);
        acc(1'b1, 16'h0024, 32'h00010007);
        // both bases: low dword hides bits 11:0
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, 16'h0028 + 16'(8 * k), 32'hffffffff);
            acc(1'b1, 16'h002c + 16'(8 * k), 32'h12345678);
            acc(1'b0, 16'h0028 + 16'(8 * k), 32'h0);
            chk(rdv, 32'hfffff000);
        end
        chk(admin_sq_base_o, 64'h12345678fffff000);
        chk(admin_cq_base_o, 64'h12345678fffff000);
        chk(admin_size_ok_o, 1'b1);
        memory_page_size_i = 4'h1; // 8K page: bit 12 set is misaligned
        repeat (2) @(posedge clk_i);
        #1 chk(admin_base_aligned_o, 1'b0);
        // admin queue of eight entries
        acc(1'b1, 16'h1000, 32'h3);
        chk(nt, 4'h1);
        chk(ad[0], 13'h3);
        chk(sq_pending_o[0], 13'h3);
        sq_head_adv_i = 4'h1; // two consumed entries
        repeat (2) @(posedge clk_i);
        #1 sq_head_adv_i = 4'h0;
        chk(sq_head_o[0], 12'h2);
        acc(1'b1, 16'h1000, 32'h1);
        chk(ad[0], 13'h6);
        chk(sq_pending_o[0], 13'h7);
        acc(1'b1, 16'h1000, 32'habcd0005);
        acc(1'b0, 16'h1000, 32'h0);
        chk(rdv, 32'h5);
        // queue one under strides 0 to 3; odd slot is not a tail
        for (int s = 0; s < 4; s++) begin
            doorbell_stride_i = 4'(s);
            acc(1'b1, 16'h1000 + (16'h8 << s), 32'(3 * (s + 1)));
            chk(nt, 4'h2);
            chk(ad[1], 13'h3);
            acc(1'b1, 16'h1000 + (16'h4 << s), 32'h1);
            chk(nt, 4'h0);
        end
        doorbell_stride_i = 4'h0;
        acc(1'b1, 16'h1018, 32'h4); // queue three not allocated
        chk(nt, 4'h0);
        // completion routing: admin source then an io source
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            #1 cpl_req_i = 1'b1;
            cpl_sq_id_i = 2'(k);
            @(posedge clk_i);
            #1 cpl_req_i = 1'b0;
            chk(cpl_valid_o, 1'b1);
            chk(cpl_cq_id_o, k ? 16'h5 : 16'h0);
            chk(cpl_vector_o, k ? 11'h3 : 11'h0);
        end
        tally_and_finish();
    end
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #20000;
        err_total++;
        tally_and_finish();
    end
endmodule : admin_queue_doorbell_regs_test
